// ### hdl/dmm_pkg.sv
// Purpose: Shared constants for the multiply, minimum, negate and mask datapath.
// Assumes: 32-bit AXI4-Lite register access, one clock.
// Notes: Instruction word layout and register map are fixed here.
package dmm_pkg;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;
	localparam int ACC_W = 24;
	localparam int MA_W = 52;
	localparam int P_W = 48;
	localparam int RP_W = 16;
	localparam int FLG_W = 9;
	localparam int STS_W = 3;
	// Register byte offsets.
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_FLAGS = 8'h0C;
	localparam logic [7:0] OFF_ACC = 8'h10;
	localparam logic [7:0] OFF_XREG = 8'h20;
	localparam logic [7:0] OFF_YREG = 8'h28;
	localparam logic [7:0] OFF_MA = 8'h30;
	localparam logic [7:0] OFF_PLO = 8'h40;
	localparam logic [7:0] OFF_PHI = 8'h44;
	localparam logic [7:0] OFF_SG = 8'h48;
	localparam logic [7:0] OFF_RP = 8'h50;
	localparam logic [7:0] OFF_XWORD = 8'h60;
	localparam logic [7:0] OFF_YWORD = 8'h64;
	// Flag bit positions.
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_V = 2;
	localparam int FLG_N = 3;
	localparam int FLG_T = 4;
	localparam int FLG_VS = 5;
	localparam int FLG_VM0 = 6;
	localparam int FLG_MV = 8;
	// Interrupt status bit positions.
	localparam int STS_DONE = 0;
	localparam int STS_REJECT = 1;
	localparam int STS_GUARD = 2;
	// Instruction word fields.
	localparam int F_OPC = 0;
	localparam int F_MOVE = 4;
	localparam int F_MI = 6;
	localparam int F_XS = 7;
	localparam int F_YS = 8;
	localparam int F_AT = 9;
	localparam int F_CT = 11;
	localparam int F_SH = 13;
	localparam int F_MJ = 15;
	localparam int F_PS = 16;
	localparam int F_GD = 18;
	localparam int F_XD = 21;
	localparam int F_YD = 22;
	localparam int F_IMM = 24;
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_MINLD = 4'h1;
	localparam logic [3:0] OP_MLD = 4'h2;
	localparam logic [3:0] OP_MSB = 4'h3;
	localparam logic [3:0] OP_MUL = 4'h4;
	localparam logic [3:0] OP_NEG = 4'h5;
	localparam logic [3:0] OP_NEGT = 4'h6;
	localparam logic [3:0] OP_NMSK = 4'h7;
	localparam logic [1:0] MOV_NONE = 2'h0;
	localparam logic [1:0] MOV_ACC = 2'h1;
	localparam logic [1:0] MOV_MEM = 2'h2;
	localparam logic [1:0] MOV_TWO = 2'h3;
	localparam logic [1:0] SH_RIGHT = 2'h1;
	localparam logic [1:0] SH_LEFT = 2'h2;
	localparam logic [1:0] PTR_THREE = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [4:0] SG_IMM_FULL = 5'h10;
endpackage

// ### hdl/dmm_core.sv
// Purpose: Datapath for minimum load, multiply-load/subtract, multiply, negate, mask and no-operation.
// Assumes: One 10 MHz clock, asynchronous active-high reset, AXI4-Lite register access.
// Notes: A write to the instruction register executes it; all results commit at the next edge.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dmm_core
	import dmm_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [AXI_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq_o
);

	typedef struct packed {
		logic [AXI_DW-1:0] instr;
		logic [STS_W-1:0] sts;
		logic [STS_W-1:0] msk;
		logic [FLG_W-1:0] flg;
		logic [3:0][ACC_W-1:0] acc;
		logic [1:0][ACC_W-1:0] xr;
		logic [1:0][ACC_W-1:0] yr;
		logic [1:0][MA_W-1:0] ma;
		logic [P_W-1:0] p;
		logic [ACC_W-1:0] sg;
		logic [3:0][RP_W-1:0] rp;
		logic [ACC_W-1:0] xw;
		logic [ACC_W-1:0] yw;
		logic aw_got;
		logic w_got;
		logic [AXI_AW-1:0] awaddr;
		logic [AXI_DW-1:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0] rresp;
	} dmm_state_t;

	dmm_state_t state_q;
	dmm_state_t state_d;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic [MA_W-1:0] sext_prod(input logic [P_W-1:0] v);
		sext_prod = {{(MA_W-P_W){v[P_W-1]}}, v};
	endfunction

	// True when the value has spilled into the guard bits above bit 47.
	function automatic logic guard_spill(input logic [MA_W-1:0] v);
		guard_spill = !((&v[MA_W-1:P_W-1]) || !(|v[MA_W-1:P_W-1]));
	endfunction

	function automatic logic in_window(input logic [7:0] a, input logic [7:0] base, input logic [7:0] span);
		in_window = (a >= base) && (a < 8'(base + span));
	endfunction

	// Returns {overflow, value} of the high part of a multiplier accumulator.
	function automatic logic [ACC_W:0] acc_high(input logic [MA_W-1:0] m, input logic [1:0] sh);
		logic [ACC_W:0] r;
		r = {guard_spill(m), m[P_W-1:ACC_W]};
		if (sh == SH_RIGHT) begin
			r = {guard_spill(m), m[P_W-1], m[P_W-1:ACC_W+1]};
		end else if (sh == SH_LEFT) begin
			r = {guard_spill(m) || (m[P_W-1] != m[P_W-2]), m[P_W-2:ACC_W], 1'b0};
		end
		return r;
	endfunction

	// Returns {hit, data} for a register read.
	function automatic logic [AXI_DW:0] read_reg(input dmm_state_t s, input logic [7:0] a);
		logic [AXI_DW:0] r;
		r = {1'b1, {AXI_DW{1'b0}}};
		if (a == OFF_INSTR) begin
			r[AXI_DW-1:0] = s.instr;
		end else if (a == OFF_STATUS) begin
			r[STS_W-1:0] = s.sts;
		end else if (a == OFF_MASK) begin
			r[STS_W-1:0] = s.msk;
		end else if (a == OFF_FLAGS) begin
			r[FLG_W-1:0] = s.flg;
		end else if (in_window(a, OFF_ACC, 8'h10)) begin
			r[ACC_W-1:0] = s.acc[a[3:2]];
		end else if (in_window(a, OFF_XREG, 8'h08)) begin
			r[ACC_W-1:0] = s.xr[a[2]];
		end else if (in_window(a, OFF_YREG, 8'h08)) begin
			r[ACC_W-1:0] = s.yr[a[2]];
		end else if (in_window(a, OFF_MA, 8'h10)) begin
			r[AXI_DW-1:0] = a[2] ? AXI_DW'(s.ma[a[3]][MA_W-1:AXI_DW]) : s.ma[a[3]][AXI_DW-1:0];
		end else if (a == OFF_PLO) begin
			r[AXI_DW-1:0] = s.p[AXI_DW-1:0];
		end else if (a == OFF_PHI) begin
			r[P_W-AXI_DW-1:0] = s.p[P_W-1:AXI_DW];
		end else if (a == OFF_SG) begin
			r[ACC_W-1:0] = s.sg;
		end else if (in_window(a, OFF_RP, 8'h10)) begin
			r[RP_W-1:0] = s.rp[a[3:2]];
		end else if (a == OFF_XWORD) begin
			r[ACC_W-1:0] = s.xw;
		end else if (a == OFF_YWORD) begin
			r[ACC_W-1:0] = s.yw;
		end else begin
			r[AXI_DW] = 1'b0;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	logic [AXI_DW:0] wr_old;
	logic [AXI_DW-1:0] wr_mask;
	logic [AXI_DW-1:0] wr_val;
	logic [AXI_DW:0] rd_res;
	logic wr_fire;
	logic exec;
	logic [AXI_DW-1:0] ins;
	logic [3:0] opc;
	logic mi;
	logic [1:0] at;
	logic [1:0] ct;
	logic [1:0] ps;
	logic [P_W-1:0] prod;
	logic [MA_W-1:0] p_ext;
	logic [MA_W-1:0] ma_new;
	logic [MA_W:0] ma_sum;
	logic ma_write;
	logic [ACC_W:0] diff;
	logic min_v;
	logic min_n;
	logic min_z;
	logic [ACC_W:0] neg;
	logic neg_v;
	logic [ACC_W:0] hi;
	logic [ACC_W-1:0] mem_word;
	logic [15:0] sg_mask;
	logic [ACC_W-1:0] sg_new;
	logic [2:0] gd;

	always_comb begin
		state_d = state_q;
		wr_old = read_reg(state_q, state_q.awaddr);
		rd_res = read_reg(state_q, s_axi_araddr);
		wr_mask = {{8{state_q.wstrb[3]}}, {8{state_q.wstrb[2]}}, {8{state_q.wstrb[1]}}, {8{state_q.wstrb[0]}}};
		wr_val = (wr_old[AXI_DW-1:0] & ~wr_mask) | (state_q.wdata & wr_mask);
		wr_fire = state_q.aw_got && state_q.w_got && !state_q.bvalid;
		exec = wr_fire && (state_q.awaddr == OFF_INSTR);
		ins = wr_val;
		opc = ins[F_OPC +: 4];
		mi = ins[F_MI];
		at = ins[F_AT +: 2];
		ct = ins[F_CT +: 2];
		ps = ins[F_PS +: 2];
		gd = ins[F_GD +: 3];
		prod = P_W'($signed(state_q.xr[ins[F_XS]]) * $signed(state_q.yr[ins[F_YS]]));
		p_ext = sext_prod(state_q.p);
		ma_sum = {state_q.ma[mi][MA_W-1], state_q.ma[mi]} - {p_ext[MA_W-1], p_ext};
		ma_new = p_ext;
		ma_write = 1'b0;
		diff = {1'b0, state_q.acc[ct]} + {1'b0, ~state_q.acc[at]} + (ACC_W+1)'(1);
		min_v = (state_q.acc[ct][ACC_W-1] != state_q.acc[at][ACC_W-1]) &&
			(diff[ACC_W-1] != state_q.acc[ct][ACC_W-1]);
		min_n = min_v ^ diff[ACC_W-1];
		min_z = (diff[ACC_W-1:0] == '0);
		neg = {1'b0, ~state_q.acc[at]} + (ACC_W+1)'(1);
		neg_v = (state_q.acc[at] == {1'b1, {(ACC_W-1){1'b0}}});
		hi = acc_high(state_q.ma[ins[F_MJ]], ins[F_SH +: 2]);
		mem_word = ps[1] ? state_q.yw : state_q.xw;
		sg_mask = 16'((17'h1 << ins[F_IMM +: 4]) - 17'h1);
		sg_new = {8'h00, state_q.sg[15:0] & sg_mask};

		// Write channel: address and data are taken independently.
		if (s_axi_awvalid && s_axi_awready) begin
			state_d.aw_got = 1'b1;
			state_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_d.w_got = 1'b1;
			state_d.wdata = s_axi_wdata;
			state_d.wstrb = s_axi_wstrb;
		end
		if (state_q.bvalid && s_axi_bready) begin
			state_d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			state_d.aw_got = 1'b0;
			state_d.w_got = 1'b0;
			state_d.bvalid = 1'b1;
			state_d.bresp = (wr_old[AXI_DW] && state_q.awaddr != OFF_STATUS) ? RESP_OKAY : RESP_SLVERR;
			if (state_q.awaddr == OFF_INSTR) begin
				state_d.instr = wr_val;
			end else if (state_q.awaddr == OFF_MASK) begin
				state_d.msk = wr_val[STS_W-1:0];
			end else if (state_q.awaddr == OFF_FLAGS) begin
				state_d.flg = wr_val[FLG_W-1:0];
			end else if (in_window(state_q.awaddr, OFF_ACC, 8'h10)) begin
				state_d.acc[state_q.awaddr[3:2]] = wr_val[ACC_W-1:0];
			end else if (in_window(state_q.awaddr, OFF_XREG, 8'h08)) begin
				state_d.xr[state_q.awaddr[2]] = wr_val[ACC_W-1:0];
			end else if (in_window(state_q.awaddr, OFF_YREG, 8'h08)) begin
				state_d.yr[state_q.awaddr[2]] = wr_val[ACC_W-1:0];
			end else if (in_window(state_q.awaddr, OFF_MA, 8'h10)) begin
				if (state_q.awaddr[2]) begin
					state_d.ma[state_q.awaddr[3]][MA_W-1:AXI_DW] = wr_val[MA_W-AXI_DW-1:0];
				end else begin
					state_d.ma[state_q.awaddr[3]][AXI_DW-1:0] = wr_val;
				end
			end else if (state_q.awaddr == OFF_PLO) begin
				state_d.p[AXI_DW-1:0] = wr_val;
			end else if (state_q.awaddr == OFF_PHI) begin
				state_d.p[P_W-1:AXI_DW] = wr_val[P_W-AXI_DW-1:0];
			end else if (state_q.awaddr == OFF_SG) begin
				state_d.sg = wr_val[ACC_W-1:0];
			end else if (in_window(state_q.awaddr, OFF_RP, 8'h10)) begin
				state_d.rp[state_q.awaddr[3:2]] = wr_val[RP_W-1:0];
			end else if (state_q.awaddr == OFF_XWORD) begin
				state_d.xw = wr_val[ACC_W-1:0];
			end else if (state_q.awaddr == OFF_YWORD) begin
				state_d.yw = wr_val[ACC_W-1:0];
			end
		end

		// Read channel: one read at a time; reading status clears it.
		if (state_q.rvalid && s_axi_rready) begin
			state_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			state_d.rvalid = 1'b1;
			state_d.rdata = rd_res[AXI_DW-1:0];
			state_d.rresp = rd_res[AXI_DW] ? RESP_OKAY : RESP_SLVERR;
			if (s_axi_araddr == OFF_STATUS) begin
				state_d.sts = '0;
			end
		end

		// Instruction execution, computed from pre-instruction state only.
		if (exec) begin
			state_d.sts[STS_DONE] = 1'b1;
			unique case (opc)
				OP_MINLD: begin
					state_d.flg[FLG_C] = diff[ACC_W];
					state_d.flg[FLG_Z] = min_z;
					state_d.flg[FLG_V] = min_v;
					state_d.flg[FLG_N] = min_n;
					if (ps == PTR_THREE) begin
						state_d.sts[STS_REJECT] = 1'b1;
						state_d.flg = state_q.flg;
					end else if (min_n || min_z) begin
						state_d.acc[at] = state_q.acc[ct];
						state_d.acc[ct] = mem_word;
						state_d.rp[PTR_THREE] = state_q.rp[ps];
					end
				end
				OP_MLD, OP_MSB, OP_MUL: begin
					state_d.p = prod;
					if (opc == OP_MLD) begin
						ma_write = 1'b1;
					end else if (opc == OP_MSB) begin
						ma_write = 1'b1;
						ma_new = ma_sum[MA_W-1:0];
					end
					if (ins[F_MOVE +: 2] == MOV_ACC) begin
						state_d.acc[at] = hi[ACC_W-1:0];
						state_d.flg[FLG_Z] = (hi[ACC_W-1:0] == '0);
						state_d.flg[FLG_V] = hi[ACC_W];
						state_d.flg[FLG_N] = hi[ACC_W-1];
					end else if (ins[F_MOVE +: 2] == MOV_MEM) begin
						if (gd[2]) begin
							state_d.acc[gd[1:0]] = mem_word;
							state_d.flg[FLG_Z] = (mem_word == '0);
							state_d.flg[FLG_V] = 1'b0;
							state_d.flg[FLG_N] = mem_word[ACC_W-1];
						end else if (gd[1]) begin
							state_d.yr[gd[0]] = mem_word;
						end else begin
							state_d.xr[gd[0]] = mem_word;
						end
					end else if (ins[F_MOVE +: 2] == MOV_TWO) begin
						state_d.xr[ins[F_XD]] = state_q.xw;
						state_d.yr[ins[F_YD]] = state_q.yw;
					end
					if (ma_write) begin
						state_d.ma[mi] = ma_new;
						state_d.flg[FLG_VM0 + int'(mi)] = guard_spill(ma_new);
						if (opc == OP_MSB && (ma_sum[MA_W] != ma_sum[MA_W-1])) begin
							state_d.flg[FLG_MV] = 1'b1;
							state_d.sts[STS_GUARD] = 1'b1;
						end
					end
				end
				OP_NEG, OP_NEGT: begin
					if (opc == OP_NEG || state_q.flg[FLG_T]) begin
						state_d.acc[at] = neg[ACC_W-1:0];
						state_d.flg[FLG_C] = neg[ACC_W];
						state_d.flg[FLG_Z] = (neg[ACC_W-1:0] == '0);
						state_d.flg[FLG_V] = neg_v;
						state_d.flg[FLG_N] = neg_v ^ neg[ACC_W-1];
					end
				end
				OP_NMSK: begin
					state_d.sg = sg_new;
					state_d.flg[FLG_Z] = (sg_new == '0);
					state_d.flg[FLG_VS] = 1'b0;
					state_d.flg[FLG_N] = sg_new[ACC_W-1];
				end
				OP_NOP: begin
				end
				default: begin
					state_d.sts[STS_REJECT] = 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register and outputs.

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign s_axi_awready = !state_q.aw_got && !state_q.bvalid;
	assign s_axi_wready = !state_q.w_got && !state_q.bvalid;
	assign s_axi_bvalid = state_q.bvalid;
	assign s_axi_bresp = state_q.bresp;
	assign s_axi_arready = !state_q.rvalid;
	assign s_axi_rvalid = state_q.rvalid;
	assign s_axi_rdata = state_q.rdata;
	assign s_axi_rresp = state_q.rresp;
	assign irq_o = |(state_q.sts & state_q.msk);

endmodule

`default_nettype wire

// ### verification/dmm_checker.sv
// Purpose: Port timing checks for the datapath register bus and interrupt.
// Assumes: One clock, reset_i asynchronous active high.
// Notes: Bound to every dmm_core instance.
`timescale 1ns/1ps
`default_nettype none
module dmm_checker
	import dmm_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [AXI_DW-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
		else $error("read answer dropped early");
	write_commit_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	irq_rise_a: assert property ($rose(irq_o) |-> $rose(s_axi_bvalid))
		else $error("interrupt rose without a write");
	irq_fall_a: assert property ($fell(irq_o) |-> $rose(s_axi_rvalid) || $rose(s_axi_bvalid))
		else $error("interrupt fell without an access");
endmodule
bind dmm_core dmm_checker u_chk (.mclk_i(mclk_i), .reset_i(reset_i), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_o(irq_o));
`default_nettype wire

// ### verification/dmm_host_model.sv
// Purpose: Host core model issuing register accesses as an AXI4-Lite master.
// Assumes: Caller enters the tasks from procedural code; one access of each kind at a time.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module dmm_host_model
	import dmm_pkg::*;
(
	input wire logic mclk_i,
	output logic [AXI_AW-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [AXI_DW-1:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [AXI_AW-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [AXI_DW-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge mclk_i);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'h0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'h0;
				s_axi_wdata <= ~d;
			end
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge mclk_i);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'h0;
				s_axi_araddr <= ~a;
			end
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
endmodule
`default_nettype wire

// ### verification/dsp_mac_minmax_negate_ops_tb.sv
// Purpose: Self-checking bench for the multiply, minimum, negate and mask datapath.
// Assumes: Instructions are issued by writing the instruction register.
// Notes: Carry is masked where its polarity is a design choice.
`timescale 1ns/1ps
`default_nettype none
module dsp_mac_minmax_negate_ops_tb
	import dmm_pkg::*;
;
	logic mclk_i = 1'h0;
	logic reset_i = 1'h1;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_o;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	dmm_core dut (.mclk_i(mclk_i), .reset_i(reset_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_o(irq_o));
	dmm_host_model u_host (.mclk_i(mclk_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	always #50 mclk_i = ~mclk_i;
	////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		u_host.write(a, d, r);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
		logic [31:0] d;
		logic [1:0] r;
		u_host.read(a, d, r);
		chk(d & m, exp);
	endtask
	function automatic logic [31:0] fld(input logic [31:0] v, input int p);
		return v << p;
	endfunction
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rc(OFF_FLAGS, 32'h0);
		rc(OFF_STATUS, 32'h0);
		chk(irq_o, 32'h0);
		u_host.read(8'h7C, d, r);
		chk(d, 32'h0);
		chk(r, RESP_SLVERR);
		u_host.write(OFF_STATUS, 32'h7, r);
		chk(r, RESP_SLVERR);
		rc(OFF_STATUS, 32'h0);
	endtask
	task automatic t_mult;
		wr(OFF_XREG, 32'h00FFFFFF);
		wr(OFF_YREG, 32'h2);
		wr(OFF_FLAGS, 32'h1);
		wr(OFF_INSTR, OP_MUL);
		rc(OFF_PLO, 32'hFFFFFFFE);
		rc(OFF_PHI, 32'h0000FFFF);
		rc(OFF_FLAGS, 32'h1);
		wr(OFF_INSTR, OP_MLD | fld(1, F_MI));
		rc(OFF_MA + 8'h08, 32'hFFFFFFFE);
		rc(OFF_MA + 8'h0C, 32'h000FFFFF);
		rc(OFF_FLAGS, 32'h1);
		wr(OFF_XREG, 32'h3);
		wr(OFF_INSTR, OP_MSB | fld(1, F_MI));
		rc(OFF_MA + 8'h08, 32'h0);
		rc(OFF_PLO, 32'h6);
	endtask
	task automatic t_guard;
		wr(OFF_FLAGS, 32'h0);
		wr(OFF_MA, 32'h0);
		wr(OFF_MA + 8'h04, 32'h000F8000);
		wr(OFF_PLO, 32'h1);
		wr(OFF_PHI, 32'h0);
		wr(OFF_INSTR, OP_MSB);
		rc(OFF_MA + 8'h04, 32'h000F7FFF);
		rc(OFF_FLAGS, 32'h40);
		wr(OFF_INSTR, OP_MLD);
		rc(OFF_FLAGS, 32'h0);
		wr(OFF_MA + 8'h04, 32'h00080000);
		wr(OFF_MA, 32'h0);
		wr(OFF_INSTR, OP_MSB);
		rc(OFF_FLAGS, 32'h140);
		rc(OFF_STATUS, 32'h4, 32'h4);
		wr(OFF_INSTR, OP_MLD);
		rc(OFF_FLAGS, 32'h100);
	endtask
	task automatic t_move;
		logic [31:0] tab [3] = '{32'h123456, 32'h091A2B, 32'h2468AC};
		wr(OFF_MA, 32'h56000000);
		wr(OFF_MA + 8'h04, 32'h00001234);
		wr(OFF_MA + 8'h0C, 32'h00008000);
		for (int i = 0; i < 3; i++) begin
			wr(OFF_FLAGS, 32'h1);
			wr(OFF_INSTR, OP_MUL | fld(MOV_ACC, F_MOVE) | fld(3, F_AT) | fld(i, F_SH));
			rc(OFF_ACC + 8'h0C, tab[i]);
			rc(OFF_FLAGS, 32'h1);
		end
		wr(OFF_INSTR, OP_MUL | fld(MOV_ACC, F_MOVE) | fld(3, F_AT) | fld(1, F_MJ));
		rc(OFF_ACC + 8'h0C, 32'h800000);
		rc(OFF_FLAGS, 32'hD);
		wr(OFF_INSTR, OP_MUL | fld(MOV_TWO, F_MOVE) | fld(1, F_XD));
		rc(OFF_XREG + 8'h04, 32'h0);
		wr(OFF_XWORD, 32'h111111);
		wr(OFF_YWORD, 32'h222222);
		wr(OFF_INSTR, OP_MUL | fld(MOV_TWO, F_MOVE) | fld(1, F_XD));
		rc(OFF_XREG + 8'h04, 32'h111111);
		rc(OFF_YREG, 32'h222222);
		wr(OFF_INSTR, OP_MUL | fld(MOV_MEM, F_MOVE) | fld(5, F_GD));
		rc(OFF_ACC + 8'h04, 32'h111111);
		rc(OFF_FLAGS, 32'h1);
		wr(OFF_INSTR, OP_MUL | fld(MOV_MEM, F_MOVE) | fld(3, F_GD) | fld(2, F_PS));
		rc(OFF_YREG + 8'h04, 32'h222222);
	endtask
	task automatic t_min;
		logic [31:0] ins;
		ins = OP_MINLD | fld(1, F_CT);
		wr(OFF_MASK, 32'h2);
		wr(OFF_ACC, 32'hA);
		wr(OFF_ACC + 8'h04, 32'h4);
		wr(OFF_RP, 32'h1234);
		wr(OFF_RP + 8'h0C, 32'h55);
		wr(OFF_XWORD, 32'hABCD);
		wr(OFF_INSTR, ins);
		chk(irq_o, 32'h0);
		rc(OFF_ACC, 32'h4);
		rc(OFF_ACC + 8'h04, 32'hABCD);
		rc(OFF_RP + 8'h0C, 32'h1234);
		rc(OFF_FLAGS, 32'h8, 32'hE);
		wr(OFF_RP, 32'h77);
		wr(OFF_INSTR, ins);
		rc(OFF_ACC, 32'h4);
		rc(OFF_ACC + 8'h04, 32'hABCD);
		rc(OFF_RP + 8'h0C, 32'h1234);
		rc(OFF_FLAGS, 32'h0, 32'hE);
		rc(OFF_STATUS, 32'h0, 32'h2);
		wr(OFF_INSTR, ins | fld(PTR_THREE, F_PS));
		chk(irq_o, 32'h1);
		rc(OFF_ACC + 8'h04, 32'hABCD);
		rc(OFF_STATUS, 32'h2, 32'h2);
		chk(irq_o, 32'h0);
	endtask
	task automatic t_neg;
		logic [31:0] v [3] = '{32'h1, 32'h800000, 32'h0};
		logic [31:0] e [3] = '{32'hFFFFFF, 32'h800000, 32'h0};
		logic [31:0] f [3] = '{32'h8, 32'h4, 32'h2};
		for (int i = 0; i < 3; i++) begin
			wr(OFF_ACC + 8'h08, v[i]);
			wr(OFF_INSTR, OP_NEG | fld(2, F_AT));
			rc(OFF_ACC + 8'h08, e[i]);
			rc(OFF_FLAGS, f[i], 32'hE);
		end
		wr(OFF_ACC + 8'h08, 32'h5);
		wr(OFF_FLAGS, 32'h0);
		wr(OFF_INSTR, OP_NEGT | fld(2, F_AT));
		rc(OFF_ACC + 8'h08, 32'h5);
		rc(OFF_FLAGS, 32'h0);
		wr(OFF_FLAGS, 32'h10);
		wr(OFF_INSTR, OP_NEGT | fld(2, F_AT));
		rc(OFF_ACC + 8'h08, 32'hFFFFFB);
	endtask
	task automatic t_mask;
		logic [31:0] imm [3] = '{32'h3, 32'hF, 32'h0};
		logic [31:0] e [3] = '{32'h7, 32'h7FFF, 32'h0};
		logic [31:0] f [3] = '{32'h0, 32'h0, 32'h2};
		for (int i = 0; i < 3; i++) begin
			wr(OFF_FLAGS, 32'h20);
			wr(OFF_SG, 32'hFFFFFF);
			wr(OFF_INSTR, OP_NMSK | fld(imm[i], F_IMM));
			rc(OFF_SG, e[i]);
			rc(OFF_FLAGS, f[i], 32'h2A);
		end
	endtask
	initial begin
		repeat (8) @(posedge mclk_i);
		reset_i <= 1'h0;
		t_reset();
		t_mult();
		t_guard();
		t_move();
		t_min();
		t_neg();
		t_mask();
		finish_test();
	end
endmodule
`default_nettype wire
